// ===== src/adc_timing_irq_ctrl.sv
// Timing and interrupt control of a successive-approximation converter.
// Assumes the analog core delivers its digital value on conv_value and that
// trigger inputs are synchronous single-cycle or level signals.
`timescale 1ns/10ps
`default_nettype none

module adc_timing_irq_ctrl (
  input  wire logic                       clk,         // Module clock
  input  wire logic                       nrst,        // Async reset, low
  input  wire logic                       psel,        // APB select
  input  wire logic                       penable,     // APB access phase
  input  wire logic                       pwrite,      // APB write
  input  wire logic [adc_timing_pkg::ADDR_W-1:0] paddr, // APB byte address
  input  wire logic [adc_timing_pkg::DATA_W-1:0] pwdata, // APB write data
  output logic [adc_timing_pkg::DATA_W-1:0] prdata,    // APB read data
  output logic                            pready,      // APB ready
  output logic                            pslverr,     // APB error
  input  wire logic [9:0]                 conv_value,  // Converter digits
  input  wire logic                       capture_channel_trigger, // CC trig
  input  wire logic                       pwm_period_timer, // PWM period trig
  input  wire logic                       eoc_ack,     // EOC acknowledge
  input  wire logic                       err_ack,     // Error acknowledge
  output logic                            eoc_irq_line, // EOC request line
  output logic                            err_irq_line, // Error request line
  output logic                            irq,         // Masked status irq
  output logic                            sampling,    // Sample phase active
  output logic                            busy         // Conversion running
);

  // ---------------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------------
  function automatic logic hit(input logic [adc_timing_pkg::ADDR_W-1:0] a,
                               input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic mapped(
      input logic [adc_timing_pkg::ADDR_W-1:0] a);
    mapped = hit(a, adc_timing_pkg::IDX_BASIC)  |
             hit(a, adc_timing_pkg::IDX_EXT)    |
             hit(a, adc_timing_pkg::IDX_STD)    |
             hit(a, adc_timing_pkg::IDX_INJ)    |
             hit(a, adc_timing_pkg::IDX_PRIMARY)|
             hit(a, adc_timing_pkg::IDX_RESULT) |
             hit(a, adc_timing_pkg::IDX_INJRES) |
             hit(a, adc_timing_pkg::IDX_EOC_IC) |
             hit(a, adc_timing_pkg::IDX_STATUS) |
             hit(a, adc_timing_pkg::IDX_MASK)   |
             hit(a, adc_timing_pkg::IDX_STATE)  |
             hit(a, adc_timing_pkg::IDX_ERR_IC);
  endfunction

  // Legacy two-bit fields mapped onto the equivalent six-bit field values.
  function automatic adc_timing_pkg::timing_t legacy(input logic [1:0] c,
                                                    input logic [1:0] s);
    adc_timing_pkg::timing_t t;
    case (c)
      2'b00:   t.clk_div = 6'h03;
      2'b01:   t.clk_div = 6'h01;
      2'b10:   t.clk_div = 6'h0f;
      default: t.clk_div = 6'h07;
    endcase
    case (s)
      2'b00:   t.sample = 6'h00;
      2'b01:   t.sample = 6'h02;
      2'b10:   t.sample = 6'h06;
      default: t.sample = 6'h0e;
    endcase
    return t;
  endfunction

  function automatic adc_timing_pkg::timing_t fields(input logic [15:0] r);
    adc_timing_pkg::timing_t t;
    t.clk_div = r[adc_timing_pkg::B_TCLK +: 6];
    t.sample  = r[adc_timing_pkg::B_TSAMP +: 6];
    return t;
  endfunction

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic [15:0] basic_control_reg, next_basic_control_reg;
  logic [15:0] extended_timing_reg, next_extended_timing_reg;
  logic [15:0] standard_timing_reg, next_standard_timing_reg;
  logic [15:0] injected_timing_reg, next_injected_timing_reg;
  logic [15:0] primary_control_reg, next_primary_control_reg;
  logic [9:0]  result_reg, next_result_reg;
  logic [9:0]  injected_result_reg, next_injected_result_reg;
  logic        result_unread, next_result_unread;
  logic [8:0]  eoc_irq_control_reg, next_eoc_irq_control_reg;
  logic [8:0]  conversion_error_irq_control;
  logic [8:0]  next_conversion_error_irq_control;
  logic [2:0]  irq_status, next_irq_status;
  logic [2:0]  irq_mask, next_irq_mask;
  logic        start_prev, next_start_prev;
  logic        inj_prev, next_inj_prev;
  logic        cc_prev, next_cc_prev;
  logic        pwm_prev, next_pwm_prev;
  logic        std_pending, next_std_pending;
  logic        inj_pending, next_inj_pending;

  adc_timing_pkg::conv_state_t state, next_state;
  logic        cur_inj, next_cur_inj;
  logic [5:0]  pre_cnt, next_pre_cnt;
  logic [8:0]  step_cnt, next_step_cnt;
  logic [2:0]  xfer_cnt, next_xfer_cnt;
  adc_timing_pkg::timing_t cur_t, next_cur_t;

  logic [adc_timing_pkg::DATA_W-1:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_eoc_irq_line, next_err_irq_line, next_irq;
  logic next_sampling, next_busy;

  // ---------------------------------------------------------------------
  // Combinational helpers
  // ---------------------------------------------------------------------
  logic access, wr, rd;
  logic ev_eoc, ev_ovr, ev_inj, restart;
  logic std_edge, inj_edge;
  logic improved;
  logic tick;
  logic [8:0] conv_steps;
  adc_timing_pkg::timing_t std_t, inj_t;

  always_comb begin
    access = psel & penable & pready;
    wr = access & pwrite;
    rd = access & ~pwrite;
    improved = primary_control_reg[adc_timing_pkg::B_MODE] |
               extended_timing_reg[adc_timing_pkg::B_IMPROVED_TIMING_SELECT];
    if (primary_control_reg[adc_timing_pkg::B_MODE]) begin
      std_t = fields(standard_timing_reg); // RULE3
      inj_t = fields(injected_timing_reg); // RULE4
    end else if (improved) begin
      std_t = fields(extended_timing_reg); // RULE2
      inj_t = std_t;
    end else begin
      std_t = legacy(basic_control_reg[adc_timing_pkg::B_LCLK +: 2],
                     basic_control_reg[adc_timing_pkg::B_LSAMP +: 2]);
      inj_t = std_t;
    end
    // The legacy fields only reach std_t on the last branch above.  // RULE1
    tick = (pre_cnt == cur_t.clk_div); // RULE5
    case ({basic_control_reg[adc_timing_pkg::B_RES8],
           primary_control_reg[adc_timing_pkg::B_POST_CAL_DISABLE]})
      2'b00:   conv_steps = adc_timing_pkg::STEPS_10_CAL; // RULE8
      2'b01:   conv_steps = adc_timing_pkg::STEPS_10; // RULE8 RULE17
      2'b10:   conv_steps = adc_timing_pkg::STEPS_8_CAL; // RULE9
      default: conv_steps = adc_timing_pkg::STEPS_8; // RULE9 RULE17
    endcase
    std_edge = basic_control_reg[adc_timing_pkg::B_START] & ~start_prev;
    inj_edge = (basic_control_reg[adc_timing_pkg::B_INJREQ] & ~inj_prev) |
               (basic_control_reg[adc_timing_pkg::B_TRG_CC] &
                capture_channel_trigger & ~cc_prev) |
               (basic_control_reg[adc_timing_pkg::B_TRG_PWM] &
                pwm_period_timer & ~pwm_prev); // RULE15 RULE18
    // A new standard request aborts a running standard conversion.
    restart = std_edge & ~cur_inj & (state != adc_timing_pkg::ST_IDLE);
    ev_eoc = (state == adc_timing_pkg::ST_XFER) &&
             (xfer_cnt == adc_timing_pkg::XFER_CYCLES - 3'd1) && !restart;
    ev_inj = ev_eoc & cur_inj; // RULE13
    ev_ovr = ev_eoc & ~cur_inj & result_unread &
             ~primary_control_reg[adc_timing_pkg::B_MODE]; // RULE12
  end

  // ---------------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_cur_inj  = cur_inj;
    next_cur_t    = cur_t;
    next_pre_cnt  = tick ? 6'h00 : pre_cnt + 6'h01;
    next_step_cnt = step_cnt;
    next_xfer_cnt = 3'd0;
    next_std_pending = std_pending | std_edge; // RULE18
    next_inj_pending = inj_pending | inj_edge;
    case (state)
      adc_timing_pkg::ST_IDLE: begin
        next_pre_cnt  = 6'h00;
        next_step_cnt = 9'd0;
        if (inj_pending) begin
          next_state = adc_timing_pkg::ST_SAMPLE;
          next_cur_inj = 1'b1;
          next_cur_t = inj_t;
          next_inj_pending = inj_edge;
        end else if (std_pending) begin
          next_state = adc_timing_pkg::ST_SAMPLE;
          next_cur_inj = 1'b0;
          next_cur_t = std_t;
          next_std_pending = std_edge;
        end
      end
      adc_timing_pkg::ST_SAMPLE: begin
        if (tick) begin
          next_step_cnt = step_cnt + 9'd1;
          if (step_cnt + 9'd1 == adc_timing_pkg::SAMP_BASE +
              {1'b0, cur_t.sample, 2'b00}) begin // RULE6
            next_state = adc_timing_pkg::ST_CONV; // RULE7
            next_step_cnt = 9'd0;
          end
        end
      end
      adc_timing_pkg::ST_CONV: begin
        if (tick) begin
          next_step_cnt = step_cnt + 9'd1;
          if (step_cnt + 9'd1 == conv_steps) begin
            next_state = adc_timing_pkg::ST_XFER; // RULE7
            next_step_cnt = 9'd0;
          end
        end
      end
      adc_timing_pkg::ST_XFER: begin
        next_pre_cnt = 6'h00;
        next_xfer_cnt = xfer_cnt + 3'd1; // RULE7
        if (ev_eoc) begin
          next_state = adc_timing_pkg::ST_IDLE;
        end
      end
      default: next_state = adc_timing_pkg::ST_IDLE;
    endcase
    if (restart) begin
      // Drop the running one; a pending injected request still goes first.
      next_state = adc_timing_pkg::ST_IDLE;
      next_std_pending = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state    <= adc_timing_pkg::ST_IDLE;
      cur_inj  <= 1'b0;
      cur_t    <= '0;
      pre_cnt  <= 6'h00;
      step_cnt <= 9'd0;
      xfer_cnt <= 3'd0;
      std_pending <= 1'b0;
      inj_pending <= 1'b0;
    end else begin
      state    <= next_state;
      cur_inj  <= next_cur_inj;
      cur_t    <= next_cur_t;
      pre_cnt  <= next_pre_cnt;
      step_cnt <= next_step_cnt;
      xfer_cnt <= next_xfer_cnt;
      std_pending <= next_std_pending;
      inj_pending <= next_inj_pending;
    end
  end

  // ---------------------------------------------------------------------
  // Registers, flags and bus answer
  // ---------------------------------------------------------------------
  always_comb begin
    next_basic_control_reg   = basic_control_reg;
    next_extended_timing_reg = extended_timing_reg;
    next_standard_timing_reg = standard_timing_reg;
    next_injected_timing_reg = injected_timing_reg;
    next_primary_control_reg = primary_control_reg;
    next_eoc_irq_control_reg = eoc_irq_control_reg;
    next_conversion_error_irq_control = conversion_error_irq_control;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    next_result_reg = result_reg;
    next_injected_result_reg = injected_result_reg;
    next_result_unread = result_unread;
    next_start_prev = basic_control_reg[adc_timing_pkg::B_START];
    next_inj_prev   = basic_control_reg[adc_timing_pkg::B_INJREQ];
    next_cc_prev    = capture_channel_trigger;
    next_pwm_prev   = pwm_period_timer;
    next_prdata  = '0;
    next_pready  = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped(paddr);

    if (wr) begin
      if (hit(paddr, adc_timing_pkg::IDX_BASIC))
        next_basic_control_reg = pwdata[15:0];
      if (hit(paddr, adc_timing_pkg::IDX_EXT))
        next_extended_timing_reg = pwdata[15:0];
      if (hit(paddr, adc_timing_pkg::IDX_STD))
        next_standard_timing_reg = pwdata[15:0];
      if (hit(paddr, adc_timing_pkg::IDX_INJ))
        next_injected_timing_reg = pwdata[15:0];
      if (hit(paddr, adc_timing_pkg::IDX_PRIMARY))
        next_primary_control_reg = pwdata[15:0];
      // Software may set or clear the flag; a set raises a request.
      if (hit(paddr, adc_timing_pkg::IDX_EOC_IC))
        next_eoc_irq_control_reg = pwdata[8:0] & adc_timing_pkg::IC_MASK;
      if (hit(paddr, adc_timing_pkg::IDX_ERR_IC))
        next_conversion_error_irq_control =
          pwdata[8:0] & adc_timing_pkg::IC_MASK; // RULE14 RULE19
      if (hit(paddr, adc_timing_pkg::IDX_MASK))
        next_irq_mask = pwdata[2:0];
    end
    if (rd) begin
      if (hit(paddr, adc_timing_pkg::IDX_RESULT))
        next_result_unread = 1'b0;
      if (hit(paddr, adc_timing_pkg::IDX_STATUS))
        next_irq_status = 3'b000;
    end
    // Acknowledge clears the flag; hardware events below still win.
    if (eoc_ack)
      next_eoc_irq_control_reg[adc_timing_pkg::B_FLAG] = 1'b0;
    if (err_ack)
      next_conversion_error_irq_control[adc_timing_pkg::B_FLAG] = 1'b0;

    if (ev_eoc) begin
      if (cur_inj) begin
        next_injected_result_reg = conv_value;
      end else begin
        next_result_reg = conv_value;
        next_result_unread = 1'b1;
      end
      next_eoc_irq_control_reg[adc_timing_pkg::B_FLAG] = 1'b1; // RULE10
      next_irq_status[adc_timing_pkg::S_EOC] = 1'b1;
    end
    if (ev_ovr | ev_inj) begin
      next_conversion_error_irq_control[adc_timing_pkg::B_FLAG] = 1'b1; // RULE19
    end
    if (ev_ovr)
      next_irq_status[adc_timing_pkg::S_OVR] = 1'b1;
    if (ev_inj)
      next_irq_status[adc_timing_pkg::S_INJ] = 1'b1;

    // Read data is latched in the setup cycle and shown in the access cycle.
    if (psel & ~penable & ~pwrite) begin
      if (hit(paddr, adc_timing_pkg::IDX_BASIC))
        next_prdata[15:0] = basic_control_reg;
      if (hit(paddr, adc_timing_pkg::IDX_EXT))
        next_prdata[15:0] = extended_timing_reg;
      if (hit(paddr, adc_timing_pkg::IDX_STD))
        next_prdata[15:0] = standard_timing_reg;
      if (hit(paddr, adc_timing_pkg::IDX_INJ))
        next_prdata[15:0] = injected_timing_reg;
      if (hit(paddr, adc_timing_pkg::IDX_PRIMARY))
        next_prdata[15:0] = primary_control_reg;
      if (hit(paddr, adc_timing_pkg::IDX_RESULT))
        next_prdata[9:0] = result_reg;
      if (hit(paddr, adc_timing_pkg::IDX_INJRES))
        next_prdata[9:0] = injected_result_reg;
      if (hit(paddr, adc_timing_pkg::IDX_EOC_IC))
        next_prdata[8:0] = eoc_irq_control_reg;
      if (hit(paddr, adc_timing_pkg::IDX_ERR_IC))
        next_prdata[8:0] = conversion_error_irq_control;
      if (hit(paddr, adc_timing_pkg::IDX_STATUS))
        next_prdata[2:0] = irq_status;
      if (hit(paddr, adc_timing_pkg::IDX_MASK))
        next_prdata[2:0] = irq_mask;
      if (hit(paddr, adc_timing_pkg::IDX_STATE))
        next_prdata[5:0] = {result_unread, inj_pending, std_pending,
                            cur_inj, state};
    end

    // Request lines reach the interrupt controller, which routes the end
    // of conversion either to its vector or to an event transfer.
    next_eoc_irq_line = next_eoc_irq_control_reg[adc_timing_pkg::B_FLAG] &
                        next_eoc_irq_control_reg[adc_timing_pkg::B_IE];
    next_err_irq_line =
      next_conversion_error_irq_control[adc_timing_pkg::B_FLAG] &
      next_conversion_error_irq_control[adc_timing_pkg::B_IE]; // RULE16
    next_irq      = |(next_irq_status & next_irq_mask);
    next_sampling = (next_state == adc_timing_pkg::ST_SAMPLE);
    next_busy     = (next_state != adc_timing_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      basic_control_reg   <= adc_timing_pkg::REG16_RESET;
      extended_timing_reg <= adc_timing_pkg::REG16_RESET;
      standard_timing_reg <= adc_timing_pkg::REG16_RESET;
      injected_timing_reg <= adc_timing_pkg::REG16_RESET;
      primary_control_reg <= adc_timing_pkg::REG16_RESET;
      eoc_irq_control_reg <= adc_timing_pkg::IC_RESET;
      conversion_error_irq_control <= adc_timing_pkg::IC_RESET;
      irq_mask   <= 3'b000;
      irq_status <= 3'b000;
      result_reg <= 10'h000;
      injected_result_reg <= 10'h000;
      result_unread <= 1'b0;
      start_prev <= 1'b0;
      inj_prev   <= 1'b0;
      cc_prev    <= 1'b0;
      pwm_prev   <= 1'b0;
      prdata     <= '0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      eoc_irq_line <= 1'b0;
      err_irq_line <= 1'b0;
      irq      <= 1'b0;
      sampling <= 1'b0;
      busy     <= 1'b0;
    end else begin
      basic_control_reg   <= next_basic_control_reg;
      extended_timing_reg <= next_extended_timing_reg;
      standard_timing_reg <= next_standard_timing_reg;
      injected_timing_reg <= next_injected_timing_reg;
      primary_control_reg <= next_primary_control_reg;
      eoc_irq_control_reg <= next_eoc_irq_control_reg;
      conversion_error_irq_control <= next_conversion_error_irq_control;
      irq_mask   <= next_irq_mask;
      irq_status <= next_irq_status;
      result_reg <= next_result_reg;
      injected_result_reg <= next_injected_result_reg;
      result_unread <= next_result_unread;
      start_prev <= next_start_prev;
      inj_prev   <= next_inj_prev;
      cc_prev    <= next_cc_prev;
      pwm_prev   <= next_pwm_prev;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      eoc_irq_line <= next_eoc_irq_line; // RULE11
      err_irq_line <= next_err_irq_line;
      irq      <= next_irq;
      sampling <= next_sampling;
      busy     <= next_busy;
    end
  end

endmodule

`default_nettype wire

// ===== src/adc_timing_pkg.sv
// Constants, register map, field layouts and types of the converter timing
// and interrupt control block.
// Assumes an APB master with 32-bit data and byte addresses.
//
// Overview of operation
// [RULE1] Improved timing active: ignore two-bit legacy fields, use six-bit fields.
// [RULE2] Compatibility mode with improved select set: extended register times all.
// [RULE3] Enhanced mode: standard conversions timed by the standard timing register.
// [RULE4] Enhanced mode: injected conversions timed by the injected timing register.
// [RULE5] Basic clock is module clock divided by clock field plus one.
// [RULE6] Sample phase lasts four times (sample field plus two) basic periods.
// [RULE7] Conversion is sample, approximation with calibration, six-cycle transfer.
// [RULE8] Ten-bit: 52 basic periods with post-calibration, 40 without.
// [RULE9] Eight-bit: 44 basic periods with post-calibration, 32 without.
// [RULE10] Every completed conversion sets the end-of-conversion request flag.
// [RULE11] End-of-conversion request drives interrupt or peripheral event transfer.
// [RULE12] Standard mode: overwriting an unread result sets the error flag.
// [RULE13] Injected result stored in second result register sets error flag.
// [RULE14] Error control: group bit 8, flag 7, enable 6, level, group.
// [RULE15] Capture channel and PWM period signals may trigger injected conversions.
// [RULE16] Exactly two interrupt request lines leave the converter; the block also drives a third, the masked status irq.
// [RULE17] Post-calibration disable bit skips the calibration cycles.
// [RULE18] Requests are taken only on zero-to-one edges of start bits.
// [RULE19] Flags stay set until cleared or acknowledged; software set requests.
package adc_timing_pkg;

  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index.
  localparam logic [15:0] IDX_BASIC   = 16'h0000;
  localparam logic [15:0] IDX_EXT     = 16'h0001;
  localparam logic [15:0] IDX_STD     = 16'h0002;
  localparam logic [15:0] IDX_INJ     = 16'h0003;
  localparam logic [15:0] IDX_PRIMARY = 16'h0004;
  localparam logic [15:0] IDX_RESULT  = 16'h0005;
  localparam logic [15:0] IDX_INJRES  = 16'h0006;
  localparam logic [15:0] IDX_EOC_IC  = 16'h0007;
  localparam logic [15:0] IDX_STATUS  = 16'h0008;
  localparam logic [15:0] IDX_MASK    = 16'h0009;
  localparam logic [15:0] IDX_STATE   = 16'h000a;
  localparam logic [15:0] IDX_ERR_IC  = 16'hff9a;

  // Basic control register bits.
  localparam int unsigned B_START   = 0;
  localparam int unsigned B_INJREQ  = 1;
  localparam int unsigned B_RES8    = 2;
  localparam int unsigned B_TRG_CC  = 3;
  localparam int unsigned B_TRG_PWM = 4;
  localparam int unsigned B_LSAMP   = 12;
  localparam int unsigned B_LCLK    = 14;
  // Timing register fields.
  localparam int unsigned B_TCLK    = 0;
  localparam int unsigned B_TSAMP   = 8;
  localparam int unsigned B_IMPROVED_TIMING_SELECT    = 15;
  // Primary control bits.
  localparam int unsigned B_MODE    = 0;
  localparam int unsigned B_POST_CAL_DISABLE  = 1;
  // Interrupt control layout.
  localparam int unsigned B_GPX     = 8;
  localparam int unsigned B_FLAG    = 7;
  localparam int unsigned B_IE      = 6;
  localparam logic [8:0]  IC_MASK   = 9'h1ff;
  localparam logic [8:0]  IC_RESET  = 9'h000;
  // Status bits: end of conversion, overrun, injected end.
  localparam int unsigned S_EOC     = 0;
  localparam int unsigned S_OVR     = 1;
  localparam int unsigned S_INJ     = 2;

  localparam logic [15:0] REG16_RESET = 16'h0000;

  // Conversion step counts in basic clock periods; XFER_CYCLES counts module clock cycles.
  localparam logic [8:0] STEPS_10_CAL = 9'd52;
  localparam logic [8:0] STEPS_10     = 9'd40;
  localparam logic [8:0] STEPS_8_CAL  = 9'd44;
  localparam logic [8:0] STEPS_8      = 9'd32;
  localparam logic [8:0] SAMP_BASE    = 9'd8;
  localparam logic [2:0] XFER_CYCLES  = 3'd6;

  typedef struct packed {
    logic [5:0] clk_div;
    logic [5:0] sample;
  } timing_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10,
    ST_XFER   = 2'b11
  } conv_state_t;

endpackage

// ===== tb/adc_timing_irq_props.sv
// Checker for the converter timing block, bound to its top module.
// Assumes zero-wait APB answers and registered status outputs.
`timescale 1ns/10ps
`default_nettype none
module adc_timing_irq_props (
  input wire logic clk, nrst, psel, penable, pwrite, pready, pslverr,
  input wire logic err_ack, eoc_irq_line, err_irq_line, sampling, busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready is not one access cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_busy_samp: assert property ($rose(busy) |-> sampling)
    else $error("conversion did not open with sampling");
  chk_samp_min: assert property ($rose(sampling) |-> sampling[*8])
    else $error("sample phase shorter than 8 periods");
  chk_conv_min: assert property ($fell(sampling) |-> busy[*8])
    else $error("conversion phase too short");
  chk_eoc_cause: assert property ($rose(eoc_irq_line) |-> $past(busy, 2))
    else $error("eoc line rose without a conversion");
  // A software write lands at the access edge, so the line follows at once.
  chk_err_cause: assert property ($rose(err_irq_line) |->
    $past(busy, 2) || $past(psel && penable && pwrite))
    else $error("error line rose without cause");
  chk_ack_clear: assert property (err_ack && !busy |-> ##2 !err_irq_line)
    else $error("acknowledge did not clear error line");
  cover property ($rose(sampling));
  cover property ($rose(err_irq_line));
  cover property (pslverr);
endmodule
`default_nettype wire

// ===== tb/adc_trigger_model.sv
// Stand-in for the timer units that may start injected conversions.
// Assumes the bench asks for pulses on fire: bit 0 capture, bit 1 PWM.
`timescale 1ns/10ps
`default_nettype none
module adc_trigger_model (
  input  wire logic       clk,  // Module clock
  input  wire logic [1:0] fire, // Pulse requests
  output logic            cc,   // Capture channel trigger
  output logic            pwm,  // PWM period match
  output logic [9:0]      value // Converter digits
);
  // One-cycle pulses: the shortest event an edge detector must catch.
  always_ff @(posedge clk) begin
    cc  <= fire[0];
    pwm <= fire[1];
  end
  assign value = 10'h2a5;
endmodule
`default_nettype wire

// ===== tb/adc_timing_interrupt_ctrl_test.sv
// Self-checking bench: APB register tasks and timed conversion runs.
// Assumes the trigger model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module adc_timing_interrupt_ctrl_test;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, eoc_ack = 1'b0, err_ack = 1'b0;
  logic [1:0]  fire = 2'b00;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdat;
  logic        pready, pslverr, cc, pwm, eoc_irq_line, err_irq_line, irq;
  logic        sampling, busy, serr;
  logic [9:0]  value;
  int          err_total = 0, check_count = 0, tn = 0;
  always #20 clk = ~clk;
  adc_trigger_model part (.clk(clk), .fire(fire), .cc(cc), .pwm(pwm),
    .value(value));
  adc_timing_irq_ctrl dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_value(value),
    .capture_channel_trigger(cc), .pwm_period_timer(pwm), .eoc_ack(eoc_ack),
    .err_ack(err_ack), .eoc_irq_line(eoc_irq_line), .irq(irq),
    .err_irq_line(err_irq_line), .sampling(sampling), .busy(busy));
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, i, 2'b00, d};
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task run(input logic [15:0] pr, ti, tv, st, input logic [1:0] f,
           input int d, s, n, input logic [31:0] sx);
    int a, b, k;
    {a, b, k} = 96'h0;
    apb(1, 16'h0004, {16'h0, pr});
    apb(1, ti, {16'h0, tv});
    apb(1, 16'h0000, {16'h0, st});
    @(posedge clk) fire <= f;
    @(posedge clk) fire <= 2'b00;
    while (busy !== 1'b1 && k < 300) begin @(posedge clk); k++; end
    while (busy === 1'b1 && k < 3000) begin
      a += sampling;
      b += !sampling;
      @(posedge clk);
      k++;
    end
    chk(a, 4 * (s + 2) * (d + 1));
    chk(b, n * (d + 1) + 6);
    apb(1, 16'h0000, 32'h0);
    chk({eoc_irq_line, irq}, 2'b11);
    apb(0, 16'h0008, 32'h0);
    chk(rdat, sx);
    chk(err_irq_line, |sx[2:1]);
    @(posedge clk) {eoc_ack, err_ack} <= 2'b11;
    @(posedge clk) {eoc_ack, err_ack} <= 2'b00;
    repeat (2) @(posedge clk);
    chk({eoc_irq_line, err_irq_line, irq}, 3'b000);
    $display("test %0d done", tn++);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(0, adc_timing_pkg::IDX_ERR_IC, 32'h0);
    chk(rdat, 32'h0);
    apb(1, adc_timing_pkg::IDX_ERR_IC, 32'hffff);
    apb(0, adc_timing_pkg::IDX_ERR_IC, 32'h0);
    chk(rdat, 32'h1ff);
    chk(err_irq_line, 1'b1);
    apb(1, adc_timing_pkg::IDX_ERR_IC, 32'h40);
    apb(1, 16'h0007, 32'h40);
    apb(1, 16'h0009, 32'h7);
    apb(0, 16'h000b, 32'h0);
    chk({serr, rdat[30:0]}, 32'h80000000);
    run(16'h0, 16'h0001, 16'h8001, 16'hc001, 0, 1, 0, 52, 1);
    run(16'h2, 16'h0001, 16'h8100, 16'hc005, 0, 0, 1, 32, 3);
    apb(0, 16'h0005, 32'h0);
    chk(rdat, {22'h0, value});
    run(16'h1, 16'h0002, 16'h0002, 16'hc005, 0, 2, 0, 44, 1);
    run(16'h3, 16'h0003, 16'h0200, 16'hc002, 0, 0, 2, 40, 5);
    run(16'h3, 16'h0003, 16'h0101, 16'h0010, 2, 1, 1, 40, 5);
    run(16'h3, 16'h0003, 16'h0101, 16'h0008, 1, 1, 1, 40, 5);
    apb(0, 16'h0006, 32'h0);
    chk(rdat, {22'h0, value});
    run(16'h0, 16'h0001, 16'h0000, 16'h5001, 0, 1, 2, 52, 3);
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize;
  end
endmodule
bind adc_timing_irq_ctrl adc_timing_irq_props chk_u (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .err_ack(err_ack), .eoc_irq_line(eoc_irq_line),
  .err_irq_line(err_irq_line), .sampling(sampling), .busy(busy));
`default_nettype wire
